// ===== cmcfg_regs.sv
// Clock, compatible-mode and control-channel watchdog configuration registers with their logic
`default_nettype none
module cmcfg_regs #(
   parameter int WD_STEP_CYC = cmcfg_pkg::WD_STEP_CYCLES
) (
   input  wire logic                        ref_clk_in,
   input  wire logic                        resetn_in,
   input  wire cmcfg_pkg::cmcfg_reg_req_t   reg_req_in,
   output logic [7:0]                       reg_rdata_out,
   output logic                             reg_rvalid_out,
   input  wire logic                        rx_lock_in,
   input  wire cmcfg_pkg::cmcfg_autoload_t  autoload_in,
   input  wire logic [2:0]                  mode_in,
   input  wire logic                        ext_clk_detected_in,
   input  wire logic                        external_ref_input_tick_in,
   input  wire logic                        fwd_rate_tick_in,
   input  wire logic                        cc_busy_in,
   output logic                             internal_ref_tick_out,
   output logic                             oscillator_freq_select_out,
   output logic                             use_internal_osc_out,
   output logic                             compat_video_active_out,
   output logic                             raw10_compat_active_out,
   output logic                             raw12_compat_active_out,
   output logic                             sensor_ref_clock_out,
   output logic                             cc_abort_out
);
   import cmcfg_pkg::*;

   typedef enum logic [2:0] {
      WD_IDLE  = 3'b001,
      WD_RUN   = 3'b010,
      WD_ABORT = 3'b100
   } cmcfg_wd_state_t;

   logic [7:0]      compat_q, refclk_q, clklo_q, clkhi_q, wdog_q;
   logic            lock_q;
   logic            lock_rise;
   logic            wr_compat;
   logic [2:0]      ref_cnt_q;
   logic [3:0]      ref_mask;
   logic [3:0]      hs_cnt_q;
   logic            hs_tick_q;
   logic [7:0]      acc_q;
   logic [7:0]      acc_d;
   logic [4:0]      m_eff;
   logic [8:0]      acc_sum;
   logic [31:0]     step_cnt_q;
   logic            step_tick;
   logic [6:0]      unit_cnt_q;
   logic            wd_off;
   cmcfg_wd_state_t wd_state_q;

   // Divide code to a mask of low counter bits that must all be one
   function automatic logic [3:0] div_mask(input logic [2:0] code);
      unique case (code)
         3'h0:    div_mask = 4'h0;
         3'h1:    div_mask = 4'h1;
         3'h2:    div_mask = 4'h3;
         3'h3:    div_mask = 4'h7;
         default: div_mask = 4'hF;
      endcase
   endfunction

   assign wr_compat = reg_req_in.wr && (reg_req_in.addr == ADDR_COMPAT);
   assign lock_rise = rx_lock_in && !lock_q;
   assign wd_off    = wdog_q[WDOFF_BIT];

   // Lock edge detector; the lock level is already synchronous
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         lock_q <= 1'b0;
      end else begin
         lock_q <= rx_lock_in;
      end
   end

   // Compatible mode register; a software write in the lock-edge cycle wins
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         compat_q <= RST_COMPAT;
      end else if (wr_compat) begin
         compat_q <= reg_req_in.wdata;
      end else if (lock_rise && !compat_q[INHIBIT_BIT]) begin
         compat_q[RAW10_BIT] <= autoload_in.raw10;
         compat_q[RAW12_BIT] <= autoload_in.raw12;
      end
   end

   // Remaining configuration registers, all bits plain read/write
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         refclk_q <= RST_REFCLK;
         clklo_q  <= RST_SENSOR_REF_CLOCK_OUT_L;
         clkhi_q  <= RST_SENSOR_REF_CLOCK_OUT_H;
         wdog_q   <= RST_WDOG;
      end else if (reg_req_in.wr) begin
         if (reg_req_in.addr == ADDR_REFCLK) refclk_q <= reg_req_in.wdata;
         if (reg_req_in.addr == ADDR_SENSOR_REF_CLOCK_OUT_L) clklo_q <= reg_req_in.wdata;
         if (reg_req_in.addr == ADDR_SENSOR_REF_CLOCK_OUT_H) clkhi_q <= reg_req_in.wdata;
         if (reg_req_in.addr == ADDR_WDOG) wdog_q <= reg_req_in.wdata;
      end
   end

   // Read data one cycle after the request; unmapped offsets read zero
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         reg_rdata_out  <= 8'h00;
         reg_rvalid_out <= 1'b0;
      end else begin
         reg_rvalid_out <= reg_req_in.rd;
         if (reg_req_in.rd) begin
            unique case (reg_req_in.addr)
               ADDR_COMPAT:   reg_rdata_out <= compat_q;
               ADDR_REFCLK:   reg_rdata_out <= refclk_q;
               ADDR_SENSOR_REF_CLOCK_OUT_L: reg_rdata_out <= clklo_q;
               ADDR_SENSOR_REF_CLOCK_OUT_H: reg_rdata_out <= clkhi_q;
               ADDR_WDOG:     reg_rdata_out <= wdog_q;
               default:       reg_rdata_out <= 8'h00;
            endcase
         end
      end
   end

   // Mode decode and reference source selection
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         compat_video_active_out    <= 1'b0;
         raw10_compat_active_out    <= 1'b0;
         raw12_compat_active_out    <= 1'b0;
         oscillator_freq_select_out <= 1'b0;
         use_internal_osc_out       <= 1'b0;
      end else begin
         compat_video_active_out    <= (mode_in == MODE_COMPAT_VIDEO);
         raw10_compat_active_out    <= (mode_in == MODE_COMPAT_VIDEO) && compat_q[RAW10_BIT];
         raw12_compat_active_out    <= (mode_in == MODE_COMPAT_VIDEO) && compat_q[RAW12_BIT];
         oscillator_freq_select_out <= refclk_q[OSC_BIT];
         use_internal_osc_out       <= !ext_clk_detected_in;
      end
   end

   // Mask of the selected code; reserved codes are caught by the top code bit before it is used
   assign ref_mask = div_mask(refclk_q[REFDIV_LSB +: 3]);

   // External reference divider; reserved codes fall back to divide by one
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         ref_cnt_q             <= 3'h0;
         internal_ref_tick_out <= 1'b0;
      end else begin
         internal_ref_tick_out <= 1'b0;
         if (external_ref_input_tick_in) begin
            ref_cnt_q <= ref_cnt_q + 3'h1;
            if (refclk_q[REFDIV_LSB+2]) begin
               internal_ref_tick_out <= 1'b1;
            end else begin
               internal_ref_tick_out <= ((ref_cnt_q & ref_mask[2:0]) == ref_mask[2:0]);
            end
         end
      end
   end

   // High-speed predivider ahead of the M/N stage; codes 4 and above act as 16
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         hs_cnt_q  <= 4'h0;
         hs_tick_q <= 1'b0;
      end else begin
         hs_tick_q <= 1'b0;
         if (fwd_rate_tick_in) begin
            hs_cnt_q  <= hs_cnt_q + 4'h1;
            hs_tick_q <= ((hs_cnt_q & div_mask(clklo_q[HSDIV_LSB +: 3]))
                          == div_mask(clklo_q[HSDIV_LSB +: 3]));
         end
      end
   end

   // M/N phase accumulator; N of zero freezes the accumulator and holds the output low rather than divide by zero
   always_comb begin
      m_eff   = (clklo_q[M_LSB +: 5] == 5'h00) ? 5'h01 : clklo_q[M_LSB +: 5];
      acc_sum = {1'b0, acc_q} + {4'h0, m_eff};
      acc_d   = acc_q;
      if (hs_tick_q && (clkhi_q != 8'h00)) begin
         acc_d = (acc_sum >= {1'b0, clkhi_q}) ? 8'(acc_sum - {1'b0, clkhi_q}) : acc_sum[7:0];
      end
   end

   // Output clock is high for the upper half of each accumulator turn
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         acc_q                <= 8'h00;
         sensor_ref_clock_out <= 1'b0;
      end else begin
         acc_q                <= acc_d;
         sensor_ref_clock_out <= (acc_d >= {1'b0, clkhi_q[7:1]}) && (clkhi_q != 8'h00);
      end
   end

   // Step counter making one 2 ms tick while a transaction runs
   assign step_tick = (wd_state_q == WD_RUN) && (step_cnt_q == 32'(WD_STEP_CYC - 1));
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         step_cnt_q <= 32'h0000_0000;
         unit_cnt_q <= 7'h00;
      end else if (wd_state_q != WD_RUN) begin
         step_cnt_q <= 32'h0000_0000;
         unit_cnt_q <= 7'h00;
      end else if (step_tick) begin
         step_cnt_q <= 32'h0000_0000;
         if (unit_cnt_q != 7'h7F) unit_cnt_q <= unit_cnt_q + 7'h01;
      end else begin
         step_cnt_q <= step_cnt_q + 32'h0000_0001;
      end
   end

   // Watchdog state; a zero timeout aborts at the first step
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         wd_state_q   <= WD_IDLE;
         cc_abort_out <= 1'b0;
      end else begin
         cc_abort_out <= 1'b0;
         unique case (wd_state_q)
            WD_IDLE: begin
               if (cc_busy_in && !wd_off) wd_state_q <= WD_RUN;
            end
            WD_RUN: begin
               if (!cc_busy_in || wd_off) begin
                  wd_state_q <= WD_IDLE;
               end else if (step_tick && ((unit_cnt_q + 7'h01) >= wdog_q[WD_LSB +: 7])) begin
                  wd_state_q   <= WD_ABORT;
                  cc_abort_out <= 1'b1;
               end
            end
            WD_ABORT: begin
               if (!cc_busy_in) wd_state_q <= WD_IDLE;
            end
         endcase
      end
   end

   // Checks
   autoload_raw10_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
      (lock_rise && !compat_q[INHIBIT_BIT] && !wr_compat) |=> compat_q[RAW10_BIT] == $past(autoload_in.raw10))
      else $error("raw-10 bit not loaded at lock");
   autoload_raw12_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
      (lock_rise && !compat_q[INHIBIT_BIT] && !wr_compat) |=> compat_q[RAW12_BIT] == $past(autoload_in.raw12))
      else $error("raw-12 bit not loaded at lock");
   inhibit_hold_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
      (compat_q[INHIBIT_BIT] && !wr_compat) |=> $stable(compat_q))
      else $error("compatible bits changed while inhibited");
   lock_level_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
      (lock_q && rx_lock_in && !wr_compat) |=> $stable(compat_q))
      else $error("compatible bits changed with lock held");
   ref_div1_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
      (external_ref_input_tick_in && refclk_q[6:4] == 3'h0) |=> internal_ref_tick_out)
      else $error("divide by one missed a reference tick");
   ref_div8_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
      (internal_ref_tick_out && $past(refclk_q[6:4]) == 3'h3) |-> $past(ref_cnt_q) == 3'h7)
      else $error("divide by eight ticked early");
   hs_div_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
      hs_tick_q |-> $past(fwd_rate_tick_in) && (($past(hs_cnt_q) & div_mask($past(clklo_q[7:5])))
                                                == div_mask($past(clklo_q[7:5]))))
      else $error("predivider ticked off count");
   m_zero_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
      (hs_tick_q && clklo_q[4:0] == 5'h00 && clkhi_q > 8'h01 && acc_q < clkhi_q - 8'h01) |=> acc_q == $past(acc_q) + 8'h01)
      else $error("zero M not used as one");
   osc_source_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
      !ext_clk_detected_in |=> use_internal_osc_out && oscillator_freq_select_out == $past(refclk_q[3]))
      else $error("internal oscillator not selected");
   wd_abort_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
      cc_abort_out |-> $past(cc_busy_in) && !$past(wd_off) && $past(unit_cnt_q) + 7'h01 >= $past(wdog_q[7:1]))
      else $error("watchdog abort without timeout");
   wd_off_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
      wd_off |=> !cc_abort_out)
      else $error("disabled watchdog aborted");
   compat_mode_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
      $past(resetn_in) |-> compat_video_active_out == $past(mode_in == MODE_COMPAT_VIDEO))
      else $error("mode 101 decode wrong");
   reg_write_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
      (reg_req_in.wr && reg_req_in.addr == ADDR_REFCLK) |=> refclk_q == $past(reg_req_in.wdata))
      else $error("reference control write lost");
   abort_pulse_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
      cc_abort_out |=> !cc_abort_out)
      else $error("abort pulse longer than one cycle");
endmodule
`default_nettype wire

// ===== cmcfg_pkg.sv
// Package with register map, field layout, reset values and timing for the clock/mode/watchdog register group
`default_nettype none
package cmcfg_pkg;
   // Register offsets
   localparam logic [7:0] ADDR_COMPAT   = 8'h04;
   localparam logic [7:0] ADDR_REFCLK   = 8'h05;
   localparam logic [7:0] ADDR_SENSOR_REF_CLOCK_OUT_L = 8'h06;
   localparam logic [7:0] ADDR_SENSOR_REF_CLOCK_OUT_H = 8'h07;
   localparam logic [7:0] ADDR_WDOG     = 8'h08;
   // Reset values (reserved bits included)
   localparam logic [7:0] RST_COMPAT    = 8'h00;
   localparam logic [7:0] RST_REFCLK    = 8'h03;
   localparam logic [7:0] RST_SENSOR_REF_CLOCK_OUT_L  = 8'h41;
   localparam logic [7:0] RST_SENSOR_REF_CLOCK_OUT_H  = 8'h28;
   localparam logic [7:0] RST_WDOG      = 8'hFE;
   // Field positions
   localparam int RAW10_BIT   = 2;
   localparam int RAW12_BIT   = 1;
   localparam int INHIBIT_BIT = 0;
   localparam int REFDIV_LSB  = 4;
   localparam int OSC_BIT     = 3;
   localparam int HSDIV_LSB   = 5;
   localparam int M_LSB       = 0;
   localparam int WD_LSB      = 1;
   localparam int WDOFF_BIT   = 0;
   // Operating mode code for the compatible parallel-video mode
   localparam logic [2:0] MODE_COMPAT_VIDEO = 3'h5;
   // Watchdog step time and its cycle count at the 10 MHz clock
   localparam int CLK_PERIOD_NS   = 100;
   localparam int WD_STEP_NS      = 2_000_000;
   localparam int WD_STEP_CYCLES  = WD_STEP_NS / CLK_PERIOD_NS;
   // Register access request
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } cmcfg_reg_req_t;
   // Compatible sub-mode values offered by the control channel at lock
   typedef struct packed {
      logic raw10;
      logic raw12;
   } cmcfg_autoload_t;
endpackage
`default_nettype wire

// ===== cmcfg_far_model.sv
// Remote-side model: drives receive lock, offered sub-mode values and control-channel activity
`default_nettype none
module cmcfg_far_model
   import cmcfg_pkg::*;
(
   input  wire logic             ref_clk_in,
   input  wire logic             lock_cmd_in,
   input  wire logic             busy_cmd_in,
   input  wire cmcfg_autoload_t  al_cmd_in,
   output var  logic             rx_lock_out,
   output var  cmcfg_autoload_t  autoload_out,
   output var  logic             cc_busy_out
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      rx_lock_out  = 1'b0;
      autoload_out = '0;
      cc_busy_out  = 1'b0;
   end
   // Changes just after the falling edge; sub-mode values only mean something while locked
   always @(negedge ref_clk_in) begin
      rx_lock_out <= lock_cmd_in;
      cc_busy_out <= busy_cmd_in;
      if (lock_cmd_in) begin
         autoload_out <= al_cmd_in;
      end else begin
         autoload_out <= ~autoload_out; // Unlocked: toggling so nothing stale is mistaken for a value
      end
   end
endmodule
`default_nettype wire

// ===== tb_clock_mode_watchdog_cfg.sv
// Self-checking bench for the clock, compatible-mode and watchdog register group
`default_nettype none
module tb_clock_mode_watchdog_cfg;
   timeunit 1ns;
   timeprecision 1ns;
   import cmcfg_pkg::*;
   localparam int STEP = 4;
   logic clk, rstn, lock_c, busy_c, rx_lock, cc_busy, ext_det, ext_tick, fwd_tick;
   logic ref_tick, osc_sel, use_osc, cv_act, r10_act, r12_act, sclk, abort_p, rvalid, sclk_q;
   logic [2:0] mode;
   logic [7:0] rdata;
   cmcfg_reg_req_t req;
   cmcfg_autoload_t al_c, al;
   int bad_count, check_count, refn, rises, n, t;
   logic [7:0] rst_tab [5] = '{RST_COMPAT, RST_REFCLK, RST_SENSOR_REF_CLOCK_OUT_L, RST_SENSOR_REF_CLOCK_OUT_H, RST_WDOG};
   cmcfg_regs #(.WD_STEP_CYC(STEP)) dut_u (.ref_clk_in(clk), .resetn_in(rstn), .reg_req_in(req),
      .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .rx_lock_in(rx_lock), .autoload_in(al),
      .mode_in(mode), .ext_clk_detected_in(ext_det), .external_ref_input_tick_in(ext_tick),
      .fwd_rate_tick_in(fwd_tick), .cc_busy_in(cc_busy), .internal_ref_tick_out(ref_tick),
      .oscillator_freq_select_out(osc_sel), .use_internal_osc_out(use_osc),
      .compat_video_active_out(cv_act), .raw10_compat_active_out(r10_act),
      .raw12_compat_active_out(r12_act), .sensor_ref_clock_out(sclk), .cc_abort_out(abort_p));
   cmcfg_far_model far_u (.ref_clk_in(clk), .lock_cmd_in(lock_c), .busy_cmd_in(busy_c),
      .al_cmd_in(al_c), .rx_lock_out(rx_lock), .autoload_out(al), .cc_busy_out(cc_busy));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // Pulse counters for the divided reference and rising edges of the sensor clock
   always @(posedge clk) begin
      sclk_q <= sclk;
      if (ref_tick === 1'b1) refn++;
      if (sclk === 1'b1 && sclk_q === 1'b0) rises++;
   end
   task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk) req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(negedge clk) req <= '0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string nm);
      @(negedge clk) req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(negedge clk) req <= '0;
      check({nm, " valid"}, rvalid, 1'b1);
      check(nm, rdata, exp);
   endtask
   task automatic cyc(input int k);
      repeat (k) @(negedge clk);
   endtask
   // Pulses one tick input for k cycles, then lets the outputs settle
   task automatic ticks(input bit fwd, input int k);
      repeat (k) begin
         @(negedge clk) if (fwd) fwd_tick <= 1'b1; else ext_tick <= 1'b1;
      end
      @(negedge clk) begin fwd_tick <= 1'b0; ext_tick <= 1'b0; end
      cyc(3);
   endtask
   initial begin
      #5_000_000;
      bad_count++;
      summarize();
   end
   initial begin
      static logic [7:0] hs [4] = '{8'h00, 8'h20, 8'h00, 8'h40};
      static logic [7:0] mv [4] = '{8'h01, 8'h01, 8'h00, 8'h02};
      static logic [7:0] nv [4] = '{8'h04, 8'h04, 8'h04, 8'h08};
      static int ex [4] = '{16, 8, 16, 4};
      static int tv [3] = '{2, 3, 127};
      rstn = 1'b0; req = '0; lock_c = 1'b0; busy_c = 1'b0; al_c = '0; mode = MODE_COMPAT_VIDEO;
      ext_det = 1'b1; ext_tick = 1'b0; fwd_tick = 1'b0; refn = 0; rises = 0; sclk_q = 1'b0;
      bad_count = 0; check_count = 0;
      repeat (12) @(posedge clk);
      @(negedge clk) rstn = 1'b1;
      // Reset values, unmapped read, then all ones through every bit including reserved ones
      for (int i = 0; i < 5; i++) rd_chk(8'(ADDR_COMPAT + i), rst_tab[i], "reset value");
      rd_chk(8'h09, 8'h00, "unmapped read");
      check("internal osc used", use_osc, 1'b0);
      for (int i = 0; i < 5; i++) wr(8'(ADDR_COMPAT + i), 8'hFF);
      for (int i = 0; i < 5; i++) rd_chk(8'(ADDR_COMPAT + i), 8'hFF, "all ones");
      check("osc select", osc_sel, 1'b1);
      for (int i = 0; i < 5; i++) wr(8'(ADDR_COMPAT + i), rst_tab[i]);
      ext_det <= 1'b0;
      cyc(3);
      check("osc select", osc_sel, 1'b0);
      check("internal osc used", use_osc, 1'b1);
      $display("test registers done");
      // Lock rise loads the sub-mode bits once; inhibit keeps software values
      al_c <= '{raw10: 1'b1, raw12: 1'b0};
      lock_c <= 1'b1;
      cyc(5);
      rd_chk(ADDR_COMPAT, 8'h04, "autoload raw10");
      check("raw10 active", r10_act, 1'b1);
      check("raw12 active", r12_act, 1'b0);
      check("compat video active", cv_act, 1'b1);
      mode <= 3'h0;
      cyc(3);
      check("raw10 active off mode", r10_act, 1'b0);
      check("compat video off mode", cv_act, 1'b0);
      mode <= MODE_COMPAT_VIDEO;
      wr(ADDR_COMPAT, 8'h00);
      cyc(4);
      rd_chk(ADDR_COMPAT, 8'h00, "no reload while locked");
      lock_c <= 1'b0;
      cyc(3);
      al_c <= '{raw10: 1'b0, raw12: 1'b1};
      lock_c <= 1'b1;
      cyc(5);
      rd_chk(ADDR_COMPAT, 8'h02, "autoload raw12");
      check("raw12 active", r12_act, 1'b1);
      lock_c <= 1'b0;
      wr(ADDR_COMPAT, 8'h01); // Software sets inhibit with its own mode bits
      al_c <= '{raw10: 1'b1, raw12: 1'b1};
      lock_c <= 1'b1;
      cyc(5);
      rd_chk(ADDR_COMPAT, 8'h01, "inhibited autoload");
      lock_c <= 1'b0;
      $display("test autoload done");
      // Reference divider: 32 back-to-back input ticks give 32 over the ratio; reserved code 4 acts as one
      for (int c = 0; c < 5; c++) begin
         wr(ADDR_REFCLK, 8'h03 | 8'(c << REFDIV_LSB));
         refn = 0;
         ticks(1'b0, 32);
         check("ref divide pulses", 16'(refn), 16'(c == 4 ? 32 : 32 >> c));
      end
      $display("test ref divider done");
      // M/N output: rising edges over 64 forward ticks, one edge of slack for the phase
      for (int i = 0; i < 4; i++) begin
         wr(ADDR_SENSOR_REF_CLOCK_OUT_H, nv[i]); // N kept non-zero, ratio far below the output limit
         wr(ADDR_SENSOR_REF_CLOCK_OUT_L, hs[i] | mv[i]);
         cyc(2);
         rises = 0;
         ticks(1'b1, 64);
         check("sensor clock edges", 16'(rises >= ex[i] - 1 && rises <= ex[i] + 1), 16'h0001);
      end
      $display("test sensor clock done");
      // Watchdog timeout in steps, one-cycle abort, and the disable bit
      for (int i = 0; i < 3; i++) begin
         wr(ADDR_WDOG, 8'(tv[i] << WD_LSB)); // Timeout never zero
         busy_c <= 1'b1;
         n = 0;
         t = tv[i] * STEP;
         while (abort_p !== 1'b1 && n < 700) begin
            @(negedge clk);
            n++;
         end
         check("abort time", 16'(n >= t && n <= t + 5), 16'h0001);
         cyc(1);
         check("abort one cycle", abort_p, 1'b0);
         busy_c <= 1'b0;
         cyc(3);
      end
      wr(ADDR_WDOG, 8'h05);
      busy_c <= 1'b1;
      n = 0;
      repeat (40) begin
         @(negedge clk);
         if (abort_p !== 1'b0) n++;
      end
      check("abort while disabled", 16'(n), 16'h0000);
      busy_c <= 1'b0;
      $display("test watchdog done");
      summarize();
   end
endmodule
`default_nettype wire
